/* dv/plps_core_asserts.sv */
// port-level property checks for the settings block
`timescale 1ns/10ps
module plps_core_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic port_role_is_up,
    input wire logic role_up,
    input wire logic role_down,
    input wire logic [3:0] max_lane_count_code,
    input wire logic [3:0] lane_count,
    input wire logic width_reserved,
    input wire logic [2:0] max_rate_code,
    input wire logic [2:0] rate_gen,
    input wire logic [15:0] lane_zero_equalizer_presets,
    input wire logic [15:0] eq_lane0_entry,
    input wire logic rate3_balance_off,
    input wire logic [2:0] cur_rate_code,
    input wire logic balance_symbols_en,
    input wire logic [15:0] turnoff_reply_delay_us,
    input wire logic turnoff_rcvd,
    input wire logic turnoff_ack_send,
    input wire logic turnoff_ack_by_user,
    input wire logic idle_inference_off,
    input wire logic idle_inferred
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // turn-off taken while the automatic reply is off
    sequence s_zero_off;
        turnoff_rcvd && turnoff_reply_delay_us == 16'h0;
    endsequence
    property p_role;
        1 |=> role_up == $past(port_role_is_up) && role_down == !$past(port_role_is_up);
    endproperty
    a_role: assert property (p_role) else $error("role outputs disagree");
    property p_width;
        1 |=> width_reserved == !$onehot($past(max_lane_count_code))
            && lane_count == (width_reserved ? 4'h0 : $past(max_lane_count_code));
    endproperty
    a_width: assert property (p_width) else $error("lane decode bad");
    property p_rate;
        1 |=> rate_gen == ($past(max_rate_code) == 3'h1 ? 3'h1 : $past(max_rate_code) == 3'h2 ? 3'h2
            : $past(max_rate_code) == 3'h4 ? 3'h3 : 3'h0);
    endproperty
    a_rate: assert property (p_rate) else $error("rate decode bad");
    property p_eq;
        1 |=> eq_lane0_entry == ($past(lane_zero_equalizer_presets) & 16'h7f7f);
    endproperty
    a_eq: assert property (p_eq) else $error("eq entry bad");
    property p_balance;
        rate3_balance_off |=> !balance_symbols_en;
    endproperty
    a_balance: assert property (p_balance) else $error("balance symbols on");
    property p_no_auto;
        turnoff_reply_delay_us == 16'h0 |-> !turnoff_ack_send;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("automatic ack with zero delay");
    property p_user_ack;
        s_zero_off |=> turnoff_ack_by_user ##1 !turnoff_ack_by_user;
    endproperty
    a_user_ack: assert property (p_user_ack) else $error("user prompt missing");
    property p_idle_off;
        idle_inference_off |=> !idle_inferred;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("idle inferred while off");
endmodule // plps_core_asserts
bind plps_core plps_core_asserts chk_u (.*);

/* dv/plps_link_partner.sv */
// far side: skip sets from the link, user logic answering the ack prompt
`timescale 1ns/10ps
module plps_link_partner (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic skp_on,
    input wire logic turnoff_ack_by_user,
    output logic skp_rcvd,
    output logic user_ack_tx
);
    logic [5:0] gap;
    // one skip set every 64 cycles, silent when off to let idle be inferred
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            gap <= 6'h0;
        else
            gap <= gap + 6'h1;
    end
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            skp_rcvd <= 1'b0;
        else
            skp_rcvd <= skp_on && gap == 6'h3f;
    end
    // user logic sends the ack itself when prompted
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            user_ack_tx <= 1'b0;
        else
            user_ack_tx <= turnoff_ack_by_user;
    end
endmodule // plps_link_partner

/* dv/tb_plps_core.sv */
// self-checking bench for the settings block
`timescale 1ns/10ps
module tb_plps_core;
    typedef struct {int k; int lo; int hi;} plps_note_s;
    logic clk, sys_rst, port_role_is_up, rate3_balance_off, idle_inference_off, widen_again_off, pme_sent;
    logic pme_answered, turnoff_rcvd, link_in_l0, fc_update_rcvd, skp_rcvd, common_clk_cfg, skp_on, user_ack_tx;
    logic pme_resend, turnoff_ack_send, turnoff_ack_by_user, role_up, role_down, width_reserved, rate_reserved;
    logic balance_symbols_en, idle_inferred, upconfig_capable, idle_q;
    logic [19:0] pme_resend_timeout_us;
    logic [15:0] turnoff_reply_delay_us, lane_zero_equalizer_presets, eq_lane0_entry, p;
    logic [3:0] max_lane_count_code, lane_count;
    logic [2:0] max_rate_code, cur_rate_code, rate_gen, rx;
    logic [7:0] ts1_fts_count;
    plps_pkg::plps_fts_pair_s fts_r1, fts_r2, fts_r3, pair;
    plps_pkg::plps_eq_fields_s eq_lane0_fields;
    int num_errors = 0, num_checks = 0, cyc = 0;
    plps_note_s notes[$];
    plps_core dut_u (.*);
    plps_link_partner partner_u (.*);
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic note(int k, int lo, int hi);
        notes.push_back('{k, cyc + lo, cyc + hi});
    endtask
    // one-cycle strobe: 0 turn-off, 1 pme sent, 2 pme answered, 3 fc update
    task automatic pulse(int which);
        {turnoff_rcvd, pme_sent, pme_answered, fc_update_rcvd} = 4'h8 >> which;
        @(negedge clk);
        {turnoff_rcvd, pme_sent, pme_answered, fc_update_rcvd} = 4'h0;
    endtask
    // monitor: each event takes the oldest note and must match kind and window
    task automatic seen(int k);
        plps_note_s n;
        n = '{-1, 0, 0};
        if (notes.size() > 0)
            n = notes.pop_front();
        num_checks++;
        if (n.k != k || cyc < n.lo || cyc > n.hi)
        begin
            num_errors++;
            $display("wrong value event expected %0d in %0d..%0d seen %0d at %0d", n.k, n.lo, n.hi, k, cyc);
        end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (pme_resend === 1'b1)
            seen(0);
        if (turnoff_ack_send === 1'b1)
            seen(1);
        if (turnoff_ack_by_user === 1'b1)
            seen(2);
        if (user_ack_tx === 1'b1)
            seen(4);
        if (idle_inferred === 1'b1 && idle_q !== 1'b1)
            seen(3);
        idle_q = idle_inferred;
        if (cyc == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    initial
    begin
        {sys_rst, skp_on} = 2'b11;
        {port_role_is_up, rate3_balance_off, idle_inference_off, widen_again_off, pme_sent, pme_answered} = 6'h0;
        {turnoff_rcvd, link_in_l0, fc_update_rcvd, common_clk_cfg, max_lane_count_code, max_rate_code} = 11'h0;
        {pme_resend_timeout_us, turnoff_reply_delay_us, cur_rate_code} = 39'h0;
        {fts_r1, fts_r2, fts_r3, lane_zero_equalizer_presets} = 64'h0;
        void'($urandom(17));
        repeat (3) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        // every width and rate code, current-rate codes 1, 2, 4 and 3 only, both clock modes
        for (int i = 0; i < 16; i++)
        begin
            max_lane_count_code = i[3:0];
            max_rate_code = i[2:0];
            cur_rate_code = (i % 4 == 3) ? 3'h3 : 3'h1 << (i % 4);
            {common_clk_cfg, port_role_is_up, rate3_balance_off, widen_again_off} = {i[2], i[0], i[3], i[1]};
            {fts_r1, fts_r2, fts_r3} = 48'({$urandom, $urandom});
            lane_zero_equalizer_presets = 16'($urandom);
            repeat (2) @(negedge clk);
            p = lane_zero_equalizer_presets;
            pair = (cur_rate_code == 3'h2) ? fts_r2 : (cur_rate_code == 3'h4) ? fts_r3 : fts_r1;
            rx = (i[2:0] == 3'h1) ? 3'h1 : (i[2:0] == 3'h2) ? 3'h2 : (i[2:0] == 3'h4) ? 3'h3 : 3'h0;
            chk("lanes", $onehot(i[3:0]) ? i[3:0] : 4'h0, lane_count);
            chk("width flag", !$onehot(i[3:0]), width_reserved);
            chk("rate", rx, rate_gen);
            chk("rate flag", rx == 3'h0, rate_reserved);
            chk("role", {port_role_is_up, !port_role_is_up}, {role_up, role_down});
            chk("balance", !rate3_balance_off && cur_rate_code == 3'h4, balance_symbols_en);
            chk("fts", common_clk_cfg ? pair.shared_clk : pair.sep_clk, ts1_fts_count);
            chk("upcfg", !widen_again_off, upconfig_capable);
            chk("eq entry", p & 16'h7f7f, eq_lane0_entry);
            chk("eq fields", {p[3:0], p[6:4], p[11:8], p[14:12]}, eq_lane0_fields);
        end
        // delayed ack, second turn-off during the wait is dropped
        turnoff_reply_delay_us = 16'h2;
        note(1, 26, 80);
        pulse(0);
        repeat (10) @(negedge clk);
        pulse(0);
        repeat (120) @(negedge clk);
        turnoff_reply_delay_us = 16'h0;
        note(2, 1, 3);
        note(4, 2, 4);
        pulse(0);
        repeat (50) @(negedge clk);
        // resend twice, then answered stops it
        pme_resend_timeout_us = 20'h3;
        note(0, 50, 80);
        note(0, 125, 155);
        pulse(1);
        repeat (160) @(negedge clk);
        pulse(2);
        repeat (300) @(negedge clk);
        // silence in L0 infers idle; traffic clears it; disable holds it off
        link_in_l0 = 1'b1;
        skp_on = 1'b0;
        note(3, 3130, 3210);
        repeat (3300) @(negedge clk);
        pulse(3);
        chk("idle cleared", 1'b0, idle_inferred);
        idle_inference_off = 1'b1;
        repeat (3400) @(negedge clk);
        chk("pending notes", 16'h0, 16'(notes.size()));
        report_and_stop();
    end
endmodule // tb_plps_core

/* logic/plps_core.sv */
// settings-driven power-management timing and physical-layer control
`timescale 1ns/10ps
`include "plps_defines.svh"
// Behaviour
// RQ1 - resend unanswered PME after set microseconds
// RQ2 - after turn-off, wait delay then acknowledge
// RQ3 - zero delay means no automatic acknowledge
// RQ4 - user logic then sends acknowledge itself
// RQ5 - role bit: up-facing when true
// RQ6 - decode width code one-hot 1/2/4/8 lanes
// RQ7 - decode speed code 2.5/5/8 GT/s
// RQ8 - balance-off stops rate-3 DC balance symbols
// RQ9 - infer idle after 128 us silence
// RQ10 - idle inference off suppresses inference
// RQ11 - advertise shared-clock FTS count if common
// RQ12 - otherwise advertise separate-clock FTS count
// RQ13 - choose FTS pair of current rate
// RQ14 - widen-again off hides upconfigure ability
// RQ15 - copy lane-0 presets into equalizer entry
// RQ16 - downstream presets at bits 3:0, 6:4
// RQ17 - upstream presets at bits 11:8, 14:12
module plps_core (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [19:0] pme_resend_timeout_us,
    input wire logic [15:0] turnoff_reply_delay_us,
    input wire logic port_role_is_up,
    input wire logic [3:0] max_lane_count_code,
    input wire logic [2:0] max_rate_code,
    input wire logic rate3_balance_off,
    input wire logic idle_inference_off,
    input wire plps_pkg::plps_fts_pair_s fts_r1,
    input wire plps_pkg::plps_fts_pair_s fts_r2,
    input wire plps_pkg::plps_fts_pair_s fts_r3,
    input wire logic widen_again_off,
    input wire logic [15:0] lane_zero_equalizer_presets,
    input wire logic pme_sent,
    input wire logic pme_answered,
    input wire logic turnoff_rcvd,
    input wire logic link_in_l0,
    input wire logic fc_update_rcvd,
    input wire logic skp_rcvd,
    input wire logic [2:0] cur_rate_code,
    input wire logic common_clk_cfg,
    output logic pme_resend,
    output logic turnoff_ack_send,
    output logic turnoff_ack_by_user,
    output logic role_up,
    output logic role_down,
    output logic [3:0] lane_count,
    output logic width_reserved,
    output logic [2:0] rate_gen,
    output logic rate_reserved,
    output logic balance_symbols_en,
    output logic idle_inferred,
    output logic [7:0] ts1_fts_count,
    output logic upconfig_capable,
    output plps_pkg::plps_eq_fields_s eq_lane0_fields,
    output logic [15:0] eq_lane0_entry
);
    localparam int IDLE_CYC = `PLPS_IDLE_INFER_CYC;
    localparam int CPU = `PLPS_CYC_PER_US;

    logic us_tick;
    logic [4:0] us_div;
    logic [19:0] resend_us;
    logic resend_arm;
    logic [15:0] ack_us;
    plps_pkg::plps_ack_state_e ack_state;
    logic [12:0] idle_cyc;
    logic [2:0] next_rate_gen;
    logic [3:0] next_lane_count;
    plps_pkg::plps_fts_pair_s cur_pair;

    // lane count from one-hot width code; reserved codes give zero lanes
    function automatic logic [3:0] decode_width(input logic [3:0] code);
        case (code)
            `PLPS_WIDTH_X1: decode_width = 4'h1;
            `PLPS_WIDTH_X2: decode_width = 4'h2;
            `PLPS_WIDTH_X4: decode_width = 4'h4;
            `PLPS_WIDTH_X8: decode_width = 4'h8;
            default: decode_width = 4'h0;
        endcase
    endfunction

    // generation number from one-hot speed code; reserved gives zero
    function automatic logic [2:0] decode_rate(input logic [2:0] code);
        case (code)
            `PLPS_RATE_R1: decode_rate = 3'h1;
            `PLPS_RATE_R2: decode_rate = 3'h2;
            `PLPS_RATE_R3: decode_rate = 3'h3;
            default: decode_rate = 3'h0;
        endcase
    endfunction

    // microsecond enable pulse, shared by both pm timers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            us_div <= 5'h00;
            us_tick <= 1'b0;
        end
        else if (us_div == 5'(CPU - 1))
        begin
            us_div <= 5'h00;
            us_tick <= 1'b1;
        end
        else
        begin
            us_div <= us_div + 5'h01;
            us_tick <= 1'b0;
        end
    end

    // pme resend timer; an answer disarms, a send (re)starts
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            resend_arm <= 1'b0;
            resend_us <= 20'h00000;
            pme_resend <= 1'b0;
        end
        else
        begin
            pme_resend <= 1'b0;
            if (pme_sent)
            begin
                resend_arm <= 1'b1;
                resend_us <= 20'h00000;
            end
            else if (pme_answered)
                resend_arm <= 1'b0;
            else if (resend_arm && us_tick)
            begin
                if (resend_us + 20'h00001 >= pme_resend_timeout_us)
                begin
                    pme_resend <= 1'b1; // RQ1
                    resend_us <= 20'h00000;
                end
                else
                    resend_us <= resend_us + 20'h00001;
            end
        end
    end

    // turn-off acknowledge sequencer
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_state <= plps_pkg::PLPS_ACK_IDLE;
            ack_us <= 16'h0000;
            turnoff_ack_send <= 1'b0;
            turnoff_ack_by_user <= 1'b0;
        end
        else
        begin
            turnoff_ack_send <= 1'b0;
            turnoff_ack_by_user <= 1'b0;
            case (ack_state)
                plps_pkg::PLPS_ACK_IDLE:
                    if (turnoff_rcvd)
                    begin
                        if (turnoff_reply_delay_us == 16'h0000)
                            turnoff_ack_by_user <= 1'b1; // RQ3 RQ4
                        else
                        begin
                            ack_us <= 16'h0000;
                            ack_state <= plps_pkg::PLPS_ACK_WAIT;
                        end
                    end
                plps_pkg::PLPS_ACK_WAIT:
                    if (us_tick)
                    begin
                        if (ack_us + 16'h0001 >= turnoff_reply_delay_us)
                            ack_state <= plps_pkg::PLPS_ACK_SEND; // RQ2
                        else
                            ack_us <= ack_us + 16'h0001;
                    end
                plps_pkg::PLPS_ACK_SEND:
                begin
                    turnoff_ack_send <= 1'b1; // RQ2
                    ack_state <= plps_pkg::PLPS_ACK_IDLE;
                end
                default: ack_state <= plps_pkg::PLPS_ACK_IDLE;
            endcase
        end
    end

    // electrical idle inference; silence counter restarts on any fc or skp
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idle_cyc <= 13'h0000;
            idle_inferred <= 1'b0;
        end
        else if (!link_in_l0 || idle_inference_off || fc_update_rcvd || skp_rcvd)
        begin
            idle_cyc <= 13'h0000; // RQ10
            idle_inferred <= 1'b0;
        end
        else if (idle_cyc >= 13'(IDLE_CYC - 1))
            idle_inferred <= 1'b1; // RQ9
        else
            idle_cyc <= idle_cyc + 13'h0001;
    end

    // pair of fts counts for the negotiated rate
    always_comb
    begin
        case (cur_rate_code)
            `PLPS_RATE_R2: cur_pair = fts_r2; // RQ13
            `PLPS_RATE_R3: cur_pair = fts_r3;
            default: cur_pair = fts_r1;
        endcase
    end

    // fts count carried in ts1; registered so it is glitch free
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ts1_fts_count <= 8'h00;
        else if (common_clk_cfg)
            ts1_fts_count <= cur_pair.shared_clk; // RQ11
        else
            ts1_fts_count <= cur_pair.sep_clk; // RQ12
    end

    assign next_lane_count = decode_width(max_lane_count_code);
    assign next_rate_gen = decode_rate(max_rate_code);

    // port role; both senses registered so every layer sees one edge
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            role_up <= 1'b0;
            role_down <= 1'b0;
        end
        else
        begin
            role_up <= port_role_is_up; // RQ5
            role_down <= !port_role_is_up; // RQ5
        end
    end

    // lane count and reserved-code flag
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lane_count <= 4'h0;
            width_reserved <= 1'b0;
        end
        else
        begin
            lane_count <= next_lane_count; // RQ6
            width_reserved <= (next_lane_count == 4'h0); // RQ6
        end
    end

    // rate generation and reserved-code flag
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rate_gen <= 3'h0;
            rate_reserved <= 1'b0;
        end
        else
        begin
            rate_gen <= next_rate_gen; // RQ7
            rate_reserved <= (next_rate_gen == 3'h0); // RQ7
        end
    end

    // symbols only matter at rate 3, so gate on the live rate too
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            balance_symbols_en <= 1'b0;
        else
            balance_symbols_en <= !rate3_balance_off && (cur_rate_code == `PLPS_RATE_R3); // RQ8
    end

    // upconfigure ability, hidden while widening again is off
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            upconfig_capable <= 1'b0;
        else
            upconfig_capable <= !widen_again_off; // RQ14
    end

    // lane-0 equalizer entry; reserved bits 7 and 15 forced to zero
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            eq_lane0_entry <= 16'h0000;
            eq_lane0_fields <= '0;
        end
        else
        begin
            eq_lane0_entry <= lane_zero_equalizer_presets & `PLPS_EQ_MASK; // RQ15
            eq_lane0_fields.dn_tx_preset <=
                lane_zero_equalizer_presets[`PLPS_EQ_DN_TX_HI:`PLPS_EQ_DN_TX_LO]; // RQ16
            eq_lane0_fields.dn_rx_hint <=
                lane_zero_equalizer_presets[`PLPS_EQ_DN_RX_HI:`PLPS_EQ_DN_RX_LO]; // RQ16
            eq_lane0_fields.up_tx_preset <=
                lane_zero_equalizer_presets[`PLPS_EQ_UP_TX_HI:`PLPS_EQ_UP_TX_LO]; // RQ17
            eq_lane0_fields.up_rx_hint <=
                lane_zero_equalizer_presets[`PLPS_EQ_UP_RX_HI:`PLPS_EQ_UP_RX_LO]; // RQ17
        end
    end
endmodule // plps_core

/* logic/plps_defines.svh */
// constants for the link power-management and physical-layer settings block
`ifndef PLPS_DEFINES_SVH
`define PLPS_DEFINES_SVH
`define PLPS_CLK_MHZ 25
`define PLPS_CYC_PER_US `PLPS_CLK_MHZ
`define PLPS_IDLE_INFER_US 128
`define PLPS_IDLE_INFER_CYC (`PLPS_IDLE_INFER_US * `PLPS_CYC_PER_US)
`define PLPS_WIDTH_X1 4'h1
`define PLPS_WIDTH_X2 4'h2
`define PLPS_WIDTH_X4 4'h4
`define PLPS_WIDTH_X8 4'h8
`define PLPS_RATE_R1 3'h1
`define PLPS_RATE_R2 3'h2
`define PLPS_RATE_R3 3'h4
`define PLPS_EQ_DN_TX_LO 0
`define PLPS_EQ_DN_TX_HI 3
`define PLPS_EQ_DN_RX_LO 4
`define PLPS_EQ_DN_RX_HI 6
`define PLPS_EQ_UP_TX_LO 8
`define PLPS_EQ_UP_TX_HI 11
`define PLPS_EQ_UP_RX_LO 12
`define PLPS_EQ_UP_RX_HI 14
`define PLPS_EQ_MASK 16'h7f7f
`endif

/* logic/plps_pkg.sv */
// types for the link power-management and physical-layer settings block
package plps_pkg;
    typedef struct packed {
        logic [7:0] shared_clk;
        logic [7:0] sep_clk;
    } plps_fts_pair_s;
    typedef struct packed {
        logic [3:0] dn_tx_preset;
        logic [2:0] dn_rx_hint;
        logic [3:0] up_tx_preset;
        logic [2:0] up_rx_hint;
    } plps_eq_fields_s;
    typedef enum logic [2:0] {
        PLPS_ACK_IDLE = 3'b001,
        PLPS_ACK_WAIT = 3'b010,
        PLPS_ACK_SEND = 3'b100
    } plps_ack_state_e;
endpackage
